/* rtl/flash_pin_pkg.sv */
// package: constants, modes and carrier types of the serial flash pin front end
package flash_pin_pkg;

  // array geometry
  localparam int unsigned ADDR_W        = 21;     // 2 Mbyte byte address
  localparam int unsigned HOST_ADDR_W   = 24;     // address width sent by the host
  localparam int unsigned PAGE_BYTES    = 256;
  localparam int unsigned PAGE_COUNT    = 8192;
  localparam int unsigned PAGE_SHIFT    = 8;
  localparam int unsigned SECTOR_SHIFT  = 12;     // 4KB, 16 pages
  localparam int unsigned BLK32_SHIFT   = 15;     // 32KB, 128 pages
  localparam int unsigned BLK64_SHIFT   = 16;     // 64KB, 256 pages
  localparam int unsigned SECTOR_COUNT  = 512;
  localparam int unsigned BLOCK_COUNT   = 32;
  localparam int unsigned SEC32_MAX_BP  = 4;      // sector protect saturates at 32KB

  // identification storage sizes
  localparam int unsigned UID_BITS      = 64;
  localparam int unsigned SEC_REG_BYTES = 256;
  localparam int unsigned SEC_REG_COUNT = 3;

  // link timing
  localparam int unsigned XIP_OVERHEAD_CLKS = 8;
  localparam real         SCK_MAX_MHZ       = 133.0;
  localparam real         CLK_MHZ           = 50.0;
  localparam int unsigned BYTE_BITS         = 8;
  localparam int unsigned WRAP_MIN_SHIFT    = 3;  // 8 byte wrap, up to 64
  localparam int unsigned FIFO_WORDS        = 16;

  // reset values
  localparam logic       CS_SYNC_RST  = 1'b0;   // no false select edge out of reset
  localparam logic       PIN_SYNC_RST = 1'b1;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_BYTE     = 4'h8;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2
  } lane_mode_t;

  typedef enum logic [1:0] {
    ERASE_SECTOR = 2'h0,
    ERASE_BLK32  = 2'h1,
    ERASE_BLK64  = 2'h2,
    ERASE_CHIP   = 2'h3
  } erase_kind_t;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] lane;        // lane_three..lane_zero levels at the pins
  } pin_in_t;

  typedef struct packed {
    logic       quad_lane_enable_bit;
    logic       status_protect_bit;
    logic       complement_protect_bit;
    logic       sector_granularity_bit;
    logic       top_bottom_bit;
    logic [2:0] block_protect;   // block_protect_bit2..0
    logic       pin_reset_select; // 0 pause, 1 reset on lane_three unless SIXTEEN_PIN
  } flash_cfg_t;

endpackage : flash_pin_pkg

/* rtl/byte_fifo.sv */
// byte_fifo: parameterised fifo with registered read data and honest full/empty
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             push;
  logic             pop;

  // memory pop refills the output register whenever it is empty or taken
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_reg != '0) && (!out_valid || out_ready);
  assign cnt_next = cnt_reg + CW'(push) - CW'(pop);

  // storage array has no reset, only data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and occupancy; ready is registered so it never glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      in_ready   <= 1'b0;
    end else begin
      wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      cnt_reg    <= cnt_next;
      in_ready   <= (cnt_next != FULL_CNT);
    end
  end

  // registered read stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : byte_fifo

/* rtl/flash_pin_front.sv */
// flash_pin_front: pin level front end of a quad serial flash, sampled on clk
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module flash_pin_front #(
  parameter int unsigned FIFO_DEPTH   = flash_pin_pkg::FIFO_WORDS,
  parameter bit          SIXTEEN_PIN  = 1'b0
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rstn,
  // pins from the host
  input  wire flash_pin_pkg::pin_in_t           pins,
  input  wire logic                             reset_pin_n,
  // pins to the host
  output logic                            [3:0] lane_out,
  output logic                            [3:0] lane_oe,
  // configuration from the status bits
  input  wire flash_pin_pkg::flash_cfg_t        cfg,
  input  wire logic                             four_wire_command_mode,
  // phase control from the command decoder
  input  wire flash_pin_pkg::lane_mode_t        lane_mode,
  input  wire logic                             tx_phase,
  input  wire logic                             prog_phase,
  input  wire logic                             wrap_en,
  input  wire logic                       [1:0] wrap_sel,
  input  wire logic                             addr_load,
  input  wire logic   [flash_pin_pkg::HOST_ADDR_W-1:0] host_addr,
  input  wire flash_pin_pkg::erase_kind_t       erase_kind,
  // read data stream into the device
  input  wire logic                             tx_valid,
  input  wire logic                       [7:0] tx_data,
  output logic                                  tx_ready,
  // captured bytes and status
  output logic                            [7:0] rx_byte_reg,
  output logic                                  rx_valid_reg,
  output logic                                  selected_reg,
  output logic                                  paused_reg,
  output logic                                  reset_req_reg,
  output logic                                  status_write_blocked_reg,
  output logic                                  addr_protected_reg,
  output logic     [flash_pin_pkg::ADDR_W-1:0]  xfer_addr_reg,
  output logic     [flash_pin_pkg::ADDR_W-1:0]  erase_base_reg
);
  import flash_pin_pkg::*;

  typedef enum logic [3:0] {
    ST_DESEL  = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_PAUSED = 4'h4,
    ST_RESET  = 4'h8
  } link_state_t;

  localparam int unsigned ID_STORE_BITS =
    UID_BITS + SEC_REG_COUNT * SEC_REG_BYTES * BYTE_BITS;
  localparam real SCK_LIMIT_MHZ = CLK_MHZ / 4.0;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // ones below bit position sh
  function automatic logic [ADDR_W-1:0] low_mask(input int unsigned sh);
    logic [ADDR_W-1:0] m;
    m = '0;
    for (int i = 0; i < ADDR_W; i++) begin
      m[i] = (i < sh);
    end
    return m;
  endfunction : low_mask

  // bits moved per clock edge
  function automatic logic [3:0] lane_step(input lane_mode_t m);
    case (m)
      LANE_DUAL: lane_step = 4'h2;
      LANE_QUAD: lane_step = 4'h4;
      default:   lane_step = 4'h1;
    endcase
  endfunction : lane_step

  // protected region test from block protect bits
  function automatic logic in_region(input flash_cfg_t c, input logic [ADDR_W-1:0] a);
    int unsigned sh;
    logic        hit;
    sh  = 0;
    hit = 1'b0;
    if (c.block_protect == 3'h0) begin
      hit = 1'b0;
    end else if (c.sector_granularity_bit) begin
      sh  = SECTOR_SHIFT + ((c.block_protect >= 3'(SEC32_MAX_BP)) ?
            (SEC32_MAX_BP - 1) : (int'(c.block_protect) - 1));
      hit = c.top_bottom_bit ? ((a & ~low_mask(sh)) == '0)
                             : ((a | low_mask(sh)) == '1);
    end else begin
      sh  = BLK64_SHIFT + int'(c.block_protect) - 1;
      sh  = (sh > ADDR_W) ? ADDR_W : sh;
      hit = c.top_bottom_bit ? ((a & ~low_mask(sh)) == '0)
                             : ((a | low_mask(sh)) == '1);
    end
    return hit ^ c.complement_protect_bit;
  endfunction : in_region

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any logic

  logic       cs_s1, cs_s2, cs_s3;
  logic       sck_s1, sck_s2, sck_s3;
  logic [3:0] lane_s1, lane_s2;
  logic       rpin_s1, rpin_s2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1   <= CS_SYNC_RST;
      cs_s2   <= CS_SYNC_RST;
      cs_s3   <= CS_SYNC_RST;
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      lane_s1 <= {4{PIN_SYNC_RST}};
      lane_s2 <= {4{PIN_SYNC_RST}};
      rpin_s1 <= PIN_SYNC_RST;
      rpin_s2 <= PIN_SYNC_RST;
    end else begin
      cs_s1   <= pins.cs_n;
      cs_s2   <= cs_s1;
      cs_s3   <= cs_s2;
      sck_s1  <= pins.sck;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      lane_s1 <= pins.lane;
      lane_s2 <= lane_s1;
      rpin_s1 <= reset_pin_n;
      rpin_s2 <= rpin_s1;
    end
  end

  logic       cs_fall, sck_rise, sck_fall;
  logic       quad_ok, hold_allowed, hold_pin_low, reset_cond;
  lane_mode_t mode_eff;

  // mode 0 or 3: only edges seen while selected count, idle level is free
  assign cs_fall  = cs_s3 && !cs_s2;
  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  // quad refused without the enable bit; falls back to one lane
  assign quad_ok  = cfg.quad_lane_enable_bit;
  assign mode_eff = (lane_mode == LANE_QUAD && !quad_ok) ? LANE_SINGLE : lane_mode;
  assign hold_allowed = !cfg.quad_lane_enable_bit && !cfg.pin_reset_select &&
                        !four_wire_command_mode && mode_eff != LANE_QUAD;
  assign hold_pin_low = !lane_s2[3];
  assign reset_cond   = SIXTEEN_PIN ? !rpin_s2
                      : (!cfg.quad_lane_enable_bit && cfg.pin_reset_select && !lane_s2[3]);

  ////////////////////////////////////////////////////////////////////////////
  // link state machine

  link_state_t state_reg, state_next;

  // the pause pin is obeyed only while the clock is low, as the pin timing demands; deselect or losing hold_allowed leaves pause at once
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DESEL:  if (cs_fall) state_next = ST_ACTIVE;
      ST_ACTIVE: begin
        if (cs_s2) state_next = ST_DESEL;
        else if (hold_allowed && hold_pin_low && !sck_s2) state_next = ST_PAUSED;
      end
      ST_PAUSED: begin
        if (cs_s2) state_next = ST_DESEL;
        else if (!hold_allowed || (!hold_pin_low && !sck_s2)) state_next = ST_ACTIVE;
      end
      ST_RESET:  state_next = ST_DESEL;
      default:   state_next = ST_DESEL;
    endcase
    if (reset_cond) state_next = ST_RESET;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_reg <= ST_RESET;
    else       state_reg <= state_next;
  end

  logic active;
  assign active = (state_reg == ST_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter: rising edges only, msb first on each lane

  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_cnt_reg, rx_sum;

  always_comb begin
    case (mode_eff)
      LANE_DUAL: rx_sh_next = {rx_sh_reg[5:0], lane_s2[1:0]};
      LANE_QUAD: rx_sh_next = {rx_sh_reg[3:0], lane_s2[3:0]};
      default:   rx_sh_next = {rx_sh_reg[6:0], lane_s2[0]};
    endcase
  end
  assign rx_sum = rx_cnt_reg + lane_step(mode_eff);

  // a paused link freezes the count, keeping partial bytes; deselect or reset clears the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh_reg    <= BYTE_RST;
      rx_cnt_reg   <= CNT_ZERO;
      rx_byte_reg  <= BYTE_RST;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (state_reg == ST_DESEL || state_reg == ST_RESET) begin
        rx_cnt_reg <= CNT_ZERO;
      end else if (active && sck_rise && !tx_phase) begin
        rx_sh_reg  <= rx_sh_next;
        rx_cnt_reg <= (rx_sum >= CNT_BYTE) ? CNT_ZERO : rx_sum;
        if (rx_sum >= CNT_BYTE) begin
          rx_byte_reg  <= rx_sh_next;
          rx_valid_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: fifo drained on falling edges, stalls while host idles

  logic       fifo_valid, fifo_pop, tx_need;
  logic [7:0] fifo_data, tx_byte;
  logic [7:0] tx_sh_reg;
  logic [3:0] tx_left_reg;

  byte_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  assign tx_need  = active && tx_phase && sck_fall && (tx_left_reg == CNT_ZERO);
  assign fifo_pop = tx_need && fifo_valid;
  // underrun sends zeros rather than stalling a host that cannot wait
  assign tx_byte  = (tx_left_reg == CNT_ZERO) ? (fifo_valid ? fifo_data : BYTE_RST)
                                              : tx_sh_reg;

  // drive lanes on falling edge, msb first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_reg   <= BYTE_RST;
      tx_left_reg <= CNT_ZERO;
      lane_out    <= 4'h0;
    end else if (state_reg == ST_DESEL || state_reg == ST_RESET) begin
      tx_left_reg <= CNT_ZERO;
    end else if (active && tx_phase && sck_fall) begin
      case (mode_eff)
        LANE_DUAL: lane_out <= {2'h0, tx_byte[7:6]};
        LANE_QUAD: lane_out <= tx_byte[7:4];
        default:   lane_out <= {2'h0, tx_byte[7], 1'b0};
      endcase
      tx_sh_reg   <= tx_byte << lane_step(mode_eff);
      tx_left_reg <= ((tx_left_reg == CNT_ZERO) ? CNT_BYTE : tx_left_reg)
                     - lane_step(mode_eff);
    end
  end

  // enables follow the state, so deselect or pause tri-states within a cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lane_oe <= 4'h0;
    end else if (state_next != ST_ACTIVE || !tx_phase) begin
      lane_oe <= 4'h0;
    end else begin
      case (mode_eff)
        LANE_DUAL: lane_oe <= 4'h3;
        LANE_QUAD: lane_oe <= 4'hF;
        default:   lane_oe <= 4'h2;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address counter: page wrap when programming, burst wrap when reading

  logic [ADDR_W-1:0] wrap_mask, addr_inc;
  logic              addr_step;

  assign wrap_mask = prog_phase ? low_mask(PAGE_SHIFT)
                   : (wrap_en ? low_mask(WRAP_MIN_SHIFT + int'(wrap_sel)) : '1);
  assign addr_step = fifo_pop || (prog_phase && rx_valid_reg);
  assign addr_inc  = ADDR_W'(xfer_addr_reg + 1'b1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xfer_addr_reg <= '0;
    end else if (addr_load) begin
      xfer_addr_reg <= host_addr[ADDR_W-1:0];
    end else if (addr_step) begin
      xfer_addr_reg <= (xfer_addr_reg & ~wrap_mask) | (addr_inc & wrap_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection and erase unit decode

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      erase_base_reg           <= '0;
      addr_protected_reg       <= 1'b0;
      status_write_blocked_reg <= 1'b0;
    end else begin
      case (erase_kind)
        ERASE_SECTOR: erase_base_reg <= xfer_addr_reg & ~low_mask(SECTOR_SHIFT);
        ERASE_BLK32:  erase_base_reg <= xfer_addr_reg & ~low_mask(BLK32_SHIFT);
        ERASE_BLK64:  erase_base_reg <= xfer_addr_reg & ~low_mask(BLK64_SHIFT);
        default:      erase_base_reg <= '0;
      endcase
      addr_protected_reg       <= in_region(cfg, xfer_addr_reg);
      status_write_blocked_reg <= cfg.status_protect_bit && !lane_s2[2] &&
                                  !cfg.quad_lane_enable_bit;
    end
  end

  // status flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selected_reg  <= 1'b0;
      paused_reg    <= 1'b0;
      reset_req_reg <= 1'b1;
    end else begin
      selected_reg  <= (state_next == ST_ACTIVE) || (state_next == ST_PAUSED);
      paused_reg    <= (state_next == ST_PAUSED);
      reset_req_reg <= (state_next == ST_RESET);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_desel_tristate: assert property (@(posedge clk) disable iff (!rstn)
    cs_s2 |=> lane_oe == 4'h0) else $error("lanes driven while deselected");
  a_no_early_byte: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == ST_DESEL |=> !rx_valid_reg) else $error("byte taken before select edge");
  a_single_lane_oe: assert property (@(posedge clk) disable iff (!rstn)
    (lane_oe != 4'h0 && $past(mode_eff) == LANE_SINGLE) |-> lane_oe == 4'h2)
    else $error("single mode drives wrong lane");
  a_quad_needs_qe: assert property (@(posedge clk) disable iff (!rstn)
    !cfg.quad_lane_enable_bit |=> lane_oe[3:2] == 2'h0) else $error("quad lanes without enable");
  a_pause_tristate: assert property (@(posedge clk) disable iff (!rstn)
    paused_reg |-> lane_oe == 4'h0 && !rx_valid_reg) else $error("activity while paused");
  a_pause_resume: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == ST_PAUSED && $past(state_reg) == ST_PAUSED) |-> $stable(rx_cnt_reg)
      && $stable(tx_left_reg)) else $error("shift state lost during pause");
  a_no_quad_pause: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.quad_lane_enable_bit || four_wire_command_mode) |=> !paused_reg)
    else $error("pause entered in quad mode");
  a_wp_blocks: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.status_protect_bit && !lane_s2[2] && !cfg.quad_lane_enable_bit) |=>
      status_write_blocked_reg) else $error("status write not blocked");
  a_reset_pin: assert property (@(posedge clk) disable iff (!rstn)
    (SIXTEEN_PIN && !rpin_s2) |=> reset_req_reg && !selected_reg)
    else $error("dedicated reset ignored");
  a_wrap_window: assert property (@(posedge clk) disable iff (!rstn)
    (addr_step && !addr_load) |=> (xfer_addr_reg & ~$past(wrap_mask)) ==
      ($past(xfer_addr_reg) & ~$past(wrap_mask))) else $error("address left wrap window");

endmodule : flash_pin_front

/* dv/spi_host_model.sv */
// spi_host_model: host partner driving select, serial clock, data and pause pins
`timescale 1ns/1ps
module spi_host_model (
  // pins toward the device
  output logic cs_n,
  output logic sck,
  output logic mosi,
  output logic hold_n
);
  localparam time HALF = 80ns;
  ////////////////////////////////////////////////////////////
  // select already low at power-up, so no falling edge is seen yet
  initial begin
    cs_n   = 1'b0;
    sck    = 1'b0;
    mosi   = 1'b0;
    hold_n = 1'b1;
  end
  // select edges happen with the clock parked low (mode 0)
  task automatic frame(input logic sel);
    #(HALF) cs_n = ~sel;
    #(HALF);
  endtask : frame
  // pause pin, pulled low to pause the selected device
  task automatic pause(input logic on);
    hold_n = ~on;
  endtask : pause
  // msb first, set while clock low, taken by the device on the rise
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      mosi = b[7-i];
      #(HALF) sck = 1'b1;
      #(HALF) sck = 1'b0;
      mosi = ~mosi; // no stale value once the bit is done
    end
  endtask : send_bits
endmodule : spi_host_model

/* dv/tb_quad_serial_flash_pin_interface.sv */
// tb_quad_serial_flash_pin_interface: self-checking bench of the flash pin front end
`timescale 1ns/1ps
module tb_quad_serial_flash_pin_interface;
  import flash_pin_pkg::*;
  logic clk, rstn, cs_n, sck, mosi, hold_n, wp_n, tx_valid, tx_ready, tx_phase;
  logic prog_phase, addr_load, rx_valid_reg, paused_reg;
  logic four_wire_command_mode, wrap_en, reset_pin_n, selected, reset_req, wr_blocked;
  logic [1:0] wrap_sel;
  logic [7:0] tx_first, rd_sh;
  logic [ADDR_W-1:0] xfer_addr, erase_base;
  logic [7:0] tx_data, rx_byte_reg;
  logic [3:0] lane_out, lane_oe, lane;
  logic [HOST_ADDR_W-1:0] host_addr;
  flash_cfg_t cfg;
  lane_mode_t lane_mode;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////
  spi_host_model host (.cs_n(cs_n), .sck(sck), .mosi(mosi), .hold_n(hold_n));
  // wire levels: device drive wins, released lane_one toggles
  assign lane = {lane_oe[3] ? lane_out[3] : hold_n, lane_oe[2] ? lane_out[2] : wp_n,
                 lane_oe[1] ? lane_out[1] : ~mosi, lane_oe[0] ? lane_out[0] : mosi};
  flash_pin_front #(.SIXTEEN_PIN(1'b1)) dut (.clk(clk), .rstn(rstn),
    .pins({cs_n, sck, lane}), .reset_pin_n(reset_pin_n),
    .lane_out(lane_out), .lane_oe(lane_oe), .cfg(cfg),
    .four_wire_command_mode(four_wire_command_mode), .lane_mode(lane_mode),
    .tx_phase(tx_phase), .prog_phase(prog_phase), .wrap_en(wrap_en), .wrap_sel(wrap_sel),
    .addr_load(addr_load), .host_addr(host_addr), .erase_kind(ERASE_SECTOR),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_byte_reg(rx_byte_reg),
    .rx_valid_reg(rx_valid_reg), .selected_reg(selected), .paused_reg(paused_reg),
    .reset_req_reg(reset_req), .status_write_blocked_reg(wr_blocked), .addr_protected_reg(),
    .xfer_addr_reg(xfer_addr), .erase_base_reg(erase_base));
  // host side of a read: lane_one sampled on each rising serial clock
  always @(posedge sck) begin
    if (tx_phase) rd_sh <= {rd_sh[6:0], lane[1]};
  end
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // captured bytes are matched against the oldest note; a byte with no note is a fault
  always @(negedge clk) begin
    if (rx_valid_reg === 1'b1) begin
      if (exp_q.size() == 0) check("rx_valid", 8'h00, 8'h01);
      else check("rx_byte", exp_q.pop_front(), rx_byte_reg);
    end
  end
  // the whole sequence needs about 12 us; far beyond that means a hang
  initial begin
    #200us;
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h8AED;
    {rstn, tx_valid, tx_phase, prog_phase, addr_load, wp_n} = 6'h01;
    {four_wire_command_mode, wrap_en, wrap_sel, reset_pin_n} = 5'h01;
    {tx_data, host_addr, lane_mode} = '0;
    cfg = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    cfg.block_protect = seed[2:0];
    host.send_bits(8'hA5, 8);
    repeat (8) @(negedge clk);
    $display("test no capture before select edge done");
    host.frame(1'b0);
    host.frame(1'b1);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      exp_q.push_back(seed[7:0]);
      host.send_bits(seed[7:0], 8);
    end
    $display("test single lane capture done");
    // pause mid-byte, wiggle the clock, then finish the byte
    seed = lfsr(seed);
    exp_q.push_back(seed[7:0]);
    host.send_bits(seed[7:0], 4);
    host.pause(1'b1);
    repeat (8) @(negedge clk);
    check("paused_reg", 8'h01, {7'h0, paused_reg});
    check("lane_oe paused", 8'h00, {4'h0, lane_oe});
    host.send_bits(8'hFF, 1);
    host.pause(1'b0);
    repeat (8) @(negedge clk);
    host.send_bits({seed[3:0], 4'h0}, 4);
    repeat (8) @(negedge clk);
    $display("test pause and resume done");
    // pause refused in four wire mode; released before the mode drops
    four_wire_command_mode = 1'b1;
    host.pause(1'b1);
    repeat (8) @(negedge clk);
    check("paused_reg four wire", 8'h00, {7'h0, paused_reg});
    host.pause(1'b0);
    repeat (4) @(negedge clk);
    four_wire_command_mode = 1'b0;
    $display("test pause refused in four wire mode done");
    // fill the fifo until it refuses
    tx_valid = 1'b1;
    for (int n = 0; n < 24 && tx_ready !== 1'b0; n++) begin
      seed = lfsr(seed);
      tx_data = seed[7:0];
      if (n == 0) tx_first = seed[7:0];
      @(negedge clk);
    end
    tx_valid = 1'b0;
    check("tx_ready full", 8'h00, {7'h0, tx_ready});
    // address one below an eight byte wrap boundary
    host_addr = {seed[23:3], 3'h7};
    {wrap_en, wrap_sel, addr_load} = 4'h9;
    @(negedge clk);
    addr_load = 1'b0;
    tx_phase = 1'b1;
    host.send_bits(8'h00, 8);
    host.send_bits(8'h00, 1); // ninth rise takes bit0, ninth fall pops again
    repeat (6) @(negedge clk);
    check("lane_oe single", 8'h02, {4'h0, lane_oe});
    check("selected_reg", 8'h01, {7'h0, selected});
    check("read byte", tx_first, rd_sh);
    check("tx_ready drained", 8'h01, {7'h0, tx_ready});
    check("xfer_addr wrap", {host_addr[20:3], 3'h1}, xfer_addr);
    check("erase_base", {host_addr[20:12], 12'h000}, erase_base);
    host.frame(1'b0);
    repeat (6) @(negedge clk);
    check("lane_oe deselected", 8'h00, {4'h0, lane_oe});
    check("pending bytes", 8'h00, 8'(exp_q.size()));
    $display("test read drive and deselect done");
    // dedicated reset pin, then write protect with status protect set
    reset_pin_n = 1'b0;
    repeat (4) @(negedge clk);
    check("reset_req_reg", 8'h01, {7'h0, reset_req});
    check("selected_reg reset", 8'h00, {7'h0, selected});
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk);
    check("reset_req_reg released", 8'h00, {7'h0, reset_req});
    cfg.status_protect_bit = 1'b1;
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    check("status write blocked", 8'h01, {7'h0, wr_blocked});
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    check("status write free", 8'h00, {7'h0, wr_blocked});
    $display("test reset pin and write protect done");
    complete_run();
  end
endmodule : tb_quad_serial_flash_pin_interface
